// ---- ncp_cache_prog_host.sv ----
// Behaviour
// - cached page program is data load then 15h, device keeps cache free.
// - sequence ends with 10h; ready returns after last page programs.
// - host refuses a cached order whose block address differs from the open sequence, and sets the sticky error.
// - full-block multi-page program steps all 64 pages, closes 81h then 10h.
// - after multi-page 15h or 10h, host reads status with 71h.
// - at most one block per district, same six-bit page in both.
// - pair load is 80h addr data 11h 81h addr data then 15h/10h.
// - inside multi-page sequence only its commands, status or reset.
// - after 8Ch give address; data input only where bytes change.
// - cached page copy stays within one district.
// - write protect held high during copy; copy ends with 8Ch then 10h.
// - copy source read is 00h confirmed by 3Ah.
// - copy intermediate pages 8Ch then 15h, final page 8Ch then 10h.
//
// Implementation choices: the address map and the address-and-strobe port.
`timescale 1ns/1ps
module ncp_cache_prog_host
	import ncp_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Software register port
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// Flash control pins
	output logic ce_n,
	output logic cle,
	output logic ale,
	output logic we_n,
	output logic re_n,
	output logic wp_n,
	// Flash data pins
	output logic [7:0] io_out,
	output logic io_oe_n,
	input wire logic [7:0] io_in,
	// Flash ready/busy
	input wire logic ready_busy_out
);
	// ==========================================================
	// Address decoding helpers
	function automatic logic [10:0] blk_of(input logic [23:0] row);
		return row[ROW_BLK_LSB +: 11];
	endfunction

	function automatic logic [5:0] page_of(input logic [23:0] row);
		return row[5:0];
	endfunction

	function automatic logic dist_of(input logic [23:0] row);
		return row[ROW_DIST_BIT];
	endfunction

	function automatic logic is_mp(input ncp_op_t op);
		return (op == OP_MP) || (op == OP_MP_END);
	endfunction

	function automatic logic is_prog(input ncp_op_t op);
		return (op == OP_CACHE) || (op == OP_CACHE_END) || is_mp(op);
	endfunction

	function automatic logic [7:0] cmd_first(input ncp_op_t op);
		if (op == OP_CP_RD) begin
			return CMD_CPREAD;
		end else if (op == OP_CP_PG || op == OP_CP_END) begin
			return CMD_CPLOAD;
		end else if (op == OP_RESET) begin
			return CMD_RESET;
		end
		return CMD_LOAD;
	endfunction

	function automatic logic [7:0] cmd_conf(input ncp_op_t op);
		// copy pages confirmed by 15h, last by 10h
		if (op == OP_CACHE || op == OP_MP || op == OP_CP_PG) begin
			return CMD_CACHE;
		end else if (op == OP_CP_RD) begin
			return CMD_CPCONF;
		end
		return CMD_FINAL;
	endfunction

	function automatic logic [7:0] addr_byte(input logic [2:0] i, input logic [15:0] col,
			input logic [23:0] row);
		case (i)
			3'h0: return col[7:0];
			3'h1: return col[15:8];
			3'h2: return row[7:0];
			3'h3: return row[15:8];
			default: return row[23:16];
		endcase
	endfunction

	// ==========================================================
	// Synchroniser and pin sequencer
	logic rb_s;
	logic [7:0] io_s;
	ncp_cyc_if cyc();

	ncp_sync #(.W(9)) u_sync (
		.ref_clk(ref_clk),
		.rst(rst),
		.d({ready_busy_out, io_in}),
		.q({rb_s, io_s})
	);

	ncp_pin_cycle u_pin (
		.ref_clk(ref_clk),
		.rst(rst),
		.cyc(cyc),
		.io_s(io_s),
		.cle(cle),
		.ale(ale),
		.we_n(we_n),
		.re_n(re_n),
		.io_out(io_out),
		.io_oe_n(io_oe_n)
	);

	ncp_ctx_t c_r, c_nxt;

	// ==========================================================
	// Register decode
	wire logic wr_ctrl, wr_col, wr_row0, wr_row1, wr_dlen, wr_data, rd_data;
	wire ncp_op_t op_in;
	assign wr_ctrl = reg_wr && (reg_addr == REG_CTRL);
	assign wr_col = reg_wr && (reg_addr == REG_COL);
	assign wr_row0 = reg_wr && (reg_addr == REG_ROW0);
	assign wr_row1 = reg_wr && (reg_addr == REG_ROW1);
	assign wr_dlen = reg_wr && (reg_addr == REG_DLEN);
	assign wr_data = reg_wr && (reg_addr == REG_DATA);
	assign rd_data = reg_rd && (reg_addr == REG_DATA);
	assign op_in = ncp_op_t'(reg_wdata[3:0]);

	wire logic busy, need_data, dlen_hit;
	assign busy = (c_r.st != S_IDLE);
	assign dlen_hit = (c_r.bcnt == c_r.dlen);
	assign need_data = (c_r.st == S_DIN) && !c_r.dfull && !dlen_hit;

	wire logic [31:0] stat_word;
	logic [31:0] rd_val;
	assign stat_word = {16'h0000, 1'b0, c_r.npages, 1'b0, rb_s, c_r.copy, c_r.seq,
		c_r.err, c_r.dval, need_data, busy};

	always_comb begin
		if (reg_addr == REG_CTRL) begin
			rd_val = {27'h0, c_r.wp_req, c_r.op};
		end else if (reg_addr == REG_COL) begin
			rd_val = {16'h0000, c_r.col};
		end else if (reg_addr == REG_ROW0) begin
			rd_val = {8'h00, c_r.row0};
		end else if (reg_addr == REG_ROW1) begin
			rd_val = {8'h00, c_r.row1};
		end else if (reg_addr == REG_DLEN) begin
			rd_val = {20'h00000, c_r.dlen};
		end else if (reg_addr == REG_DATA) begin
			rd_val = {24'h000000, c_r.dout};
		end else if (reg_addr == REG_STAT) begin
			rd_val = stat_word;
		end else if (reg_addr == REG_NSTAT) begin
			rd_val = {23'h000000, c_r.st71, c_r.nstat};
		end else begin
			rd_val = 32'h00000000;
		end
	end

	// ==========================================================
	// Order checks against the open sequence
	wire logic [10:0] blk_d0, blk_d1, key_a, key_b;
	wire logic mp_ok, seq_ok;
	logic legal;
	assign blk_d0 = dist_of(c_r.row0) ? blk_of(c_r.row1) : blk_of(c_r.row0);
	assign blk_d1 = dist_of(c_r.row0) ? blk_of(c_r.row0) : blk_of(c_r.row1);
	assign key_a = is_mp(op_in) ? blk_d0 : blk_of(c_r.row0);
	assign key_b = is_mp(op_in) ? blk_d1 : 11'h000;
	// one block per district, equal page address
	assign mp_ok = (page_of(c_r.row0) == page_of(c_r.row1))
		&& (dist_of(c_r.row0) != dist_of(c_r.row1));
	// same blocks, next page, or the sequence must restart
	// pages stepped one at a time through the block
	assign seq_ok = (key_a == c_r.blk_a) && (key_b == c_r.blk_b)
		&& (page_of(c_r.row0) == c_r.page + 6'h01);

	always_comb begin
		legal = 1'b0;
		case (op_in)
			OP_CACHE, OP_CACHE_END: begin
				legal = !c_r.copy && (!c_r.seq || (!c_r.mp && seq_ok));
			end
			// nothing foreign inside a multi-page sequence
			OP_MP, OP_MP_END: begin
				legal = !c_r.copy && mp_ok && (!c_r.seq || (c_r.mp && seq_ok));
			end
			OP_CP_RD: begin
				legal = !c_r.seq && !c_r.copy;
			end
			// copy destination in the source district
			OP_CP_PG, OP_CP_END: begin
				legal = !c_r.seq && c_r.copy && (dist_of(c_r.row0) == c_r.cdist);
			end
			OP_CP_OUT: begin
				legal = c_r.copy;
			end
			OP_STATUS, OP_RESET: begin
				legal = 1'b1;
			end
			default: begin
				legal = 1'b0;
			end
		endcase
	end

	wire logic start;
	assign start = wr_ctrl && (op_in != OP_NONE) && !busy && legal;

	// ==========================================================
	// Pin cycle requests
	wire logic [23:0] row_sel;
	wire logic issue_fixed;
	assign row_sel = c_r.half ? c_r.row1 : c_r.row0;
	assign issue_fixed = (c_r.st == S_CMD) || (c_r.st == S_ADDR) || (c_r.st == S_MID)
		|| (c_r.st == S_SECOND) || (c_r.st == S_CONF) || (c_r.st == S_STCMD)
		|| (c_r.st == S_STRD);
	assign cyc.req = issue_fixed || (need_data ? 1'b0 : (c_r.st == S_DIN) && !dlen_hit)
		|| ((c_r.st == S_DOUT) && !c_r.dval && !dlen_hit);
	assign cyc.kind = (c_r.st == S_ADDR) ? PK_ADDR : (c_r.st == S_DIN) ? PK_DIN
		: ((c_r.st == S_DOUT) || (c_r.st == S_STRD)) ? PK_DOUT : PK_CMD;
	// pair order 80h, address, data, 11h, 81h, address, data
	assign cyc.wbyte = (c_r.st == S_CMD) ? cmd_first(c_r.op)
		: (c_r.st == S_ADDR) ? addr_byte(c_r.acnt, c_r.col, row_sel)
		: (c_r.st == S_DIN) ? c_r.data
		: (c_r.st == S_MID) ? CMD_PAIR
		: (c_r.st == S_SECOND) ? CMD_LOAD2
		: (c_r.st == S_CONF) ? cmd_conf(c_r.op)
		: (c_r.st == S_STCMD) ? (c_r.st71 ? CMD_STAT2 : CMD_STAT) : 8'h00;

	// ==========================================================
	// Sequencer
	always_comb begin
		c_nxt = c_r;
		c_nxt.rdata = reg_rd ? rd_val : 32'h00000000;
		if (wr_col) begin
			c_nxt.col = reg_wdata[15:0];
		end
		if (wr_row0) begin
			c_nxt.row0 = reg_wdata[23:0];
		end
		if (wr_row1) begin
			c_nxt.row1 = reg_wdata[23:0];
		end
		if (wr_dlen) begin
			c_nxt.dlen = reg_wdata[11:0];
		end
		if (wr_data) begin
			c_nxt.data = reg_wdata[7:0];
			c_nxt.dfull = 1'b1;
		end
		if (rd_data) begin
			c_nxt.dval = 1'b0;
		end
		if (wr_ctrl) begin
			c_nxt.wp_req = reg_wdata[CTRL_WP_BIT];
			if (reg_wdata[CTRL_CLR_BIT]) begin
				c_nxt.err = 1'b0;
			end
		end
		// Refused orders leave a sticky error; setting beats clearing
		if (wr_ctrl && (op_in != OP_NONE) && !start) begin
			c_nxt.err = 1'b1;
		end
		case (c_r.st)
			S_IDLE: begin
				if (start) begin
					c_nxt.op = op_in;
					c_nxt.acnt = 3'h0;
					c_nxt.bcnt = 12'h000;
					c_nxt.half = 1'b0;
					c_nxt.st = S_RDY;
					c_nxt.ret = S_CMD;
					if (op_in == OP_STATUS) begin
						c_nxt.st = S_STCMD;
					end else if (op_in == OP_RESET) begin
						c_nxt.st = S_CMD;
						c_nxt.seq = 1'b0;
						c_nxt.copy = 1'b0;
					end else if (op_in == OP_CP_OUT) begin
						c_nxt.ret = S_DOUT;
					end
					if (is_prog(op_in)) begin
						c_nxt.st71 = is_mp(op_in);
						c_nxt.blk_a = key_a;
						c_nxt.blk_b = key_b;
						c_nxt.page = page_of(c_r.row0);
						c_nxt.npages = (c_r.seq ? c_r.npages : 7'h00) + 7'h01;
						c_nxt.seq = (op_in == OP_CACHE) || (op_in == OP_MP);
						c_nxt.mp = is_mp(op_in);
					end else if (op_in == OP_CP_RD) begin
						c_nxt.copy = 1'b1;
						c_nxt.cdist = dist_of(c_r.row0);
						c_nxt.st71 = 1'b0;
					end
				end
			end
			S_RDY: begin
				if (rb_s) begin
					c_nxt.st = c_r.ret;
				end
			end
			S_CMD: begin
				if (cyc.done) begin
					if (c_r.op == OP_RESET) begin
						c_nxt.wcnt = WB_CYC - 4'h1;
						c_nxt.ret = S_BUSY;
						c_nxt.st = S_WAIT;
					end else begin
						c_nxt.acnt = 3'h0;
						c_nxt.st = S_ADDR;
					end
				end
			end
			S_ADDR: begin
				if (cyc.done) begin
					c_nxt.acnt = c_r.acnt + 3'h1;
					if (c_r.acnt == LAST_ADDR_CYC) begin
						if (c_r.op == OP_CP_RD) begin
							c_nxt.st = S_CONF;
						end else begin
							c_nxt.wcnt = ADL_CYC - 4'h1;
							c_nxt.ret = S_DIN;
							c_nxt.st = S_WAIT;
						end
					end
				end
			end
			// a zero length sends no copy data
			S_DIN: begin
				if (dlen_hit) begin
					c_nxt.st = (is_mp(c_r.op) && !c_r.half) ? S_MID : S_CONF;
				end else if (cyc.done) begin
					c_nxt.dfull = wr_data;
					c_nxt.bcnt = c_r.bcnt + 12'h001;
				end
			end
			S_MID: begin
				if (cyc.done) begin
					c_nxt.st = S_SECOND;
				end
			end
			S_SECOND: begin
				if (cyc.done) begin
					c_nxt.half = 1'b1;
					c_nxt.acnt = 3'h0;
					c_nxt.bcnt = 12'h000;
					c_nxt.st = S_ADDR;
				end
			end
			// 15h or 10h after the data load, 3Ah after the copy read address
			S_CONF: begin
				if (cyc.done) begin
					c_nxt.wcnt = WB_CYC - 4'h1;
					c_nxt.ret = S_BUSY;
					c_nxt.st = S_WAIT;
				end
			end
			S_WAIT: begin
				if (c_r.wcnt == 4'h0) begin
					c_nxt.st = c_r.ret;
				end else begin
					c_nxt.wcnt = c_r.wcnt - 4'h1;
				end
			end
			S_BUSY: begin
				if (rb_s) begin
					c_nxt.bcnt = 12'h000;
					if (c_r.op == OP_RESET) begin
						c_nxt.st = S_IDLE;
					end else if (c_r.op == OP_CP_RD) begin
						c_nxt.st = S_DOUT;
					end else begin
						c_nxt.st = S_STCMD;
					end
				end
			end
			S_DOUT: begin
				if (dlen_hit) begin
					c_nxt.st = S_IDLE;
				end else if (cyc.done) begin
					c_nxt.dout = cyc.rbyte;
					c_nxt.dval = 1'b1;
					c_nxt.bcnt = c_r.bcnt + 12'h001;
				end
			end
			S_STCMD: begin
				if (cyc.done) begin
					c_nxt.wcnt = WHR_CYC - 4'h1;
					c_nxt.ret = S_STRD;
					c_nxt.st = S_WAIT;
				end
			end
			default: begin
				if (cyc.done) begin
					c_nxt.nstat = cyc.rbyte;
					c_nxt.st = S_IDLE;
					// copy stays open until the last page is done
					if (c_r.op == OP_CP_END) begin
						c_nxt.copy = 1'b0;
					end
				end
			end
		endcase
		// Chip stays selected across an open sequence
		c_nxt.ce_n = !((c_nxt.st != S_IDLE) || c_nxt.seq || c_nxt.copy);
		// protect released for the whole copy
		c_nxt.wp_n = !(c_nxt.wp_req && !c_nxt.copy);
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			c_r <= CTX_RST;
		end else begin
			c_r <= c_nxt;
		end
	end

	assign reg_rdata = c_r.rdata;
	assign ce_n = c_r.ce_n;
	assign wp_n = c_r.wp_n;
endmodule

// ---- ncp_pkg.sv ----
package ncp_pkg;

	// ==========================================================
	// Clock and timing
	localparam int CLK_MHZ = 25;

	function automatic int ns2cyc(input int t_ns);
		return (t_ns * CLK_MHZ + 999) / 1000;
	endfunction

	localparam int T_WP_NS = 12;
	localparam int T_WH_NS = 10;
	localparam int T_REA_NS = 20;
	localparam int T_REH_NS = 10;
	localparam int T_WB_NS = 100;
	localparam int T_ADL_NS = 70;
	localparam int T_WHR_NS = 60;
	localparam int SYNC_STAGES = 2;

	localparam logic [3:0] WE_LOW_CYC = 4'(ns2cyc(T_WP_NS));
	localparam logic [3:0] WE_HIGH_CYC = 4'(ns2cyc(T_WH_NS));
	// Read strobe also covers the two-stage input synchroniser
	localparam logic [3:0] RE_LOW_CYC = 4'(ns2cyc(T_REA_NS) + SYNC_STAGES);
	localparam logic [3:0] RE_HIGH_CYC = 4'(ns2cyc(T_REH_NS));
	localparam logic [3:0] WB_CYC = 4'(ns2cyc(T_WB_NS));
	localparam logic [3:0] ADL_CYC = 4'(ns2cyc(T_ADL_NS));
	localparam logic [3:0] WHR_CYC = 4'(ns2cyc(T_WHR_NS));

	// ==========================================================
	// Flash command bytes
	localparam logic [7:0] CMD_LOAD = 8'h80;
	localparam logic [7:0] CMD_LOAD2 = 8'h81;
	localparam logic [7:0] CMD_PAIR = 8'h11;
	localparam logic [7:0] CMD_CACHE = 8'h15;
	localparam logic [7:0] CMD_FINAL = 8'h10;
	localparam logic [7:0] CMD_CPREAD = 8'h00;
	localparam logic [7:0] CMD_CPCONF = 8'h3a;
	localparam logic [7:0] CMD_CPLOAD = 8'h8c;
	localparam logic [7:0] CMD_STAT = 8'h70;
	localparam logic [7:0] CMD_STAT2 = 8'h71;
	localparam logic [7:0] CMD_RESET = 8'hff;

	// ==========================================================
	// Address layout
	localparam logic [2:0] LAST_ADDR_CYC = 3'h4;
	localparam int ROW_BLK_LSB = 6;
	localparam int ROW_DIST_BIT = 6;

	// ==========================================================
	// Software register map
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_COL = 8'h04;
	localparam logic [7:0] REG_ROW0 = 8'h08;
	localparam logic [7:0] REG_ROW1 = 8'h0c;
	localparam logic [7:0] REG_DLEN = 8'h10;
	localparam logic [7:0] REG_DATA = 8'h14;
	localparam logic [7:0] REG_STAT = 8'h18;
	localparam logic [7:0] REG_NSTAT = 8'h1c;
	localparam int CTRL_WP_BIT = 4;
	localparam int CTRL_CLR_BIT = 5;

	// ==========================================================
	// Types
	typedef enum logic [3:0] {
		OP_NONE, OP_CACHE, OP_CACHE_END, OP_MP, OP_MP_END,
		OP_CP_RD, OP_CP_PG, OP_CP_END, OP_STATUS, OP_RESET, OP_CP_OUT
	} ncp_op_t;

	typedef enum logic [1:0] {PK_CMD, PK_ADDR, PK_DIN, PK_DOUT} ncp_kind_t;

	typedef enum {
		S_IDLE, S_RDY, S_CMD, S_ADDR, S_DIN, S_MID, S_SECOND,
		S_CONF, S_WAIT, S_BUSY, S_DOUT, S_STCMD, S_STRD
	} ncp_state_t;

	typedef struct packed {
		ncp_state_t st;
		ncp_state_t ret;
		ncp_op_t op;
		logic [3:0] wcnt;
		logic [2:0] acnt;
		logic [11:0] bcnt;
		logic half;
		logic [15:0] col;
		logic [23:0] row0;
		logic [23:0] row1;
		logic [11:0] dlen;
		logic [7:0] data;
		logic dfull;
		logic [7:0] dout;
		logic dval;
		logic err;
		logic wp_req;
		logic seq;
		logic mp;
		logic copy;
		logic cdist;
		logic [10:0] blk_a;
		logic [10:0] blk_b;
		logic [5:0] page;
		logic [6:0] npages;
		logic [7:0] nstat;
		logic st71;
		logic [31:0] rdata;
		logic ce_n;
		logic wp_n;
	} ncp_ctx_t;

	localparam ncp_ctx_t CTX_RST = '{st: S_IDLE, ret: S_IDLE, op: OP_NONE,
		ce_n: 1'b1, wp_n: 1'b1, default: '0};

endpackage

// ---- ncp_cyc_if.sv ----
`timescale 1ns/1ps
interface ncp_cyc_if;
	import ncp_pkg::*;
	logic req;
	ncp_kind_t kind;
	logic [7:0] wbyte;
	logic done;
	logic [7:0] rbyte;
	modport ctl(output req, kind, wbyte, input done, rbyte);
	modport pin(input req, kind, wbyte, output done, rbyte);
endinterface

// ---- ncp_sync.sv ----
`timescale 1ns/1ps
module ncp_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Asynchronous in, synchronous out
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_r;
	logic [W-1:0] q_r;

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			meta_r <= '0;
			q_r <= '0;
		end else begin
			meta_r <= d;
			q_r <= meta_r;
		end
	end

	assign q = q_r;
endmodule

// ---- ncp_pin_cycle.sv ----
`timescale 1ns/1ps
module ncp_pin_cycle
	import ncp_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Cycle requests
	ncp_cyc_if.pin cyc,
	// Synchronised data pins
	input wire logic [7:0] io_s,
	// Flash strobes and data
	output logic cle,
	output logic ale,
	output logic we_n,
	output logic re_n,
	output logic [7:0] io_out,
	output logic io_oe_n
);
	typedef enum {P_IDLE, P_SET, P_LOW, P_HIGH} ncp_pst_t;

	ncp_pst_t st_r, st_nxt;
	logic [3:0] cnt_r, cnt_nxt;
	ncp_kind_t kind_r, kind_nxt;
	logic [7:0] byte_r, byte_nxt;
	logic [7:0] rbyte_r, rbyte_nxt;
	logic cle_r, ale_r, we_n_r, re_n_r, oe_n_r;
	logic [7:0] io_r;
	logic is_rd, act;

	// ==========================================================
	// One strobe cycle: setup, strobe low, strobe high
	assign is_rd = (kind_nxt == PK_DOUT);
	assign act = (st_nxt != P_IDLE);
	assign cyc.done = (st_r == P_HIGH) && (cnt_r == 4'h0);
	assign cyc.rbyte = rbyte_r;

	always_comb begin
		st_nxt = st_r;
		cnt_nxt = cnt_r;
		kind_nxt = kind_r;
		byte_nxt = byte_r;
		rbyte_nxt = rbyte_r;
		case (st_r)
			P_IDLE: begin
				if (cyc.req) begin
					st_nxt = P_SET;
					kind_nxt = cyc.kind;
					byte_nxt = cyc.wbyte;
				end
			end
			P_SET: begin
				st_nxt = P_LOW;
				cnt_nxt = (kind_r == PK_DOUT) ? RE_LOW_CYC - 4'h1 : WE_LOW_CYC - 4'h1;
			end
			P_LOW: begin
				if (cnt_r == 4'h0) begin
					st_nxt = P_HIGH;
					cnt_nxt = (kind_r == PK_DOUT) ? RE_HIGH_CYC - 4'h1 : WE_HIGH_CYC - 4'h1;
					// Data has crossed the synchroniser by now
					if (kind_r == PK_DOUT) begin
						rbyte_nxt = io_s;
					end
				end else begin
					cnt_nxt = cnt_r - 4'h1;
				end
			end
			default: begin
				if (cnt_r == 4'h0) begin
					st_nxt = P_IDLE;
				end else begin
					cnt_nxt = cnt_r - 4'h1;
				end
			end
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			st_r <= P_IDLE;
			cnt_r <= 4'h0;
			kind_r <= PK_CMD;
			byte_r <= 8'h00;
			rbyte_r <= 8'h00;
		end else begin
			st_r <= st_nxt;
			cnt_r <= cnt_nxt;
			kind_r <= kind_nxt;
			byte_r <= byte_nxt;
			rbyte_r <= rbyte_nxt;
		end
	end

	// Pins follow the next state so they change with it
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			cle_r <= 1'b0;
			ale_r <= 1'b0;
			we_n_r <= 1'b1;
			re_n_r <= 1'b1;
			oe_n_r <= 1'b1;
			io_r <= 8'h00;
		end else begin
			cle_r <= act && (kind_nxt == PK_CMD);
			ale_r <= act && (kind_nxt == PK_ADDR);
			we_n_r <= !((st_nxt == P_LOW) && !is_rd);
			re_n_r <= !((st_nxt == P_LOW) && is_rd);
			oe_n_r <= !(act && !is_rd);
			io_r <= byte_nxt;
		end
	end

	assign cle = cle_r;
	assign ale = ale_r;
	assign we_n = we_n_r;
	assign re_n = re_n_r;
	assign io_out = io_r;
	assign io_oe_n = oe_n_r;
endmodule

// ---- ncp_flash_model.sv ----
`timescale 1ns/1ps
module ncp_flash_model (
	// Host strobes
	input wire logic ce_n,
	input wire logic cle,
	input wire logic ale,
	input wire logic we_n,
	input wire logic re_n,
	input wire logic wp_n,
	input wire logic [7:0] io_out,
	// Injected page results
	input wire logic [1:0] fail_in,
	// Device outputs
	output logic [7:0] io_in,
	output logic ready_busy_out
);
	logic [7:0] cq[$];
	logic [7:0] dq[$];
	logic [7:0] sb = 8'h00;
	logic [1:0] s1 = 2'h0;
	logic [1:0] s2 = 2'h0;
	logic m = 1'b0;
	// Released bus shows the inverse, never a stale byte
	assign io_in = re_n ? ~sb : sb;
	initial ready_busy_out = 1'b1;
	always @(posedge we_n) begin
		// data bytes kept for the bench
		if (!ce_n && !cle && !ale) begin
			dq.push_back(io_out);
		end
		if (!ce_n && cle) begin
			cq.push_back(io_out);
			case (io_out)
			8'h11: m = 1'b1;
			8'h80, 8'h00, 8'h8c: m = 1'b0;
			// busy till page verified, cache taken
			8'h15, 8'h10: begin
				s2 = s1;
				s1 = m ? fail_in : {1'b0, fail_in[0]};
				ready_busy_out = 1'b0;
				#(io_out == 8'h10 ? 600 : 200);
				ready_busy_out = 1'b1;
			end
			8'h3a: begin
				ready_busy_out = 1'b0;
				#400;
				sb = 8'ha5;
				ready_busy_out = 1'b1;
			end
			8'h70: sb = {wp_n, 2'b11, 3'b000, |s2, |s1};
			8'h71: sb = {wp_n, 2'b11, s2, s1, |s1};
			8'hff: begin
				s1 = 2'h0;
				s2 = 2'h0;
				ready_busy_out = 1'b0;
				#100;
				ready_busy_out = 1'b1;
			end
			default: ;
			endcase
		end
	end
endmodule

// ---- ncp_cache_prog_host_sva.sv ----
`timescale 1ns/1ps
module ncp_chk (
	// Clock, reset
	input wire logic ref_clk,
	input wire logic rst,
	// Flash pins
	input wire logic ce_n,
	input wire logic cle,
	input wire logic ale,
	input wire logic we_n,
	input wire logic re_n,
	input wire logic wp_n,
	input wire logic [7:0] io_out,
	input wire logic io_oe_n,
	input wire logic ready_busy_out
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	// ====
	// Cycles the ready pin has been low
	logic [3:0] low_r;
	always_ff @(posedge ref_clk) begin
		low_r <= (rst || ready_busy_out) ? 4'h0 : low_r + {3'h0, low_r != 4'hf};
	end
	property p_we; $fell(we_n) |=> $rose(we_n); endproperty
	a_we: assert property (p_we) else $error("we width");
	property p_re; $fell(re_n) |-> !re_n [*3] ##1 re_n; endproperty
	a_re: assert property (p_re) else $error("re width");
	property p_drv; !we_n |-> !io_oe_n && !ce_n; endproperty
	a_drv: assert property (p_drv) else $error("we drive");
	property p_rel; !re_n |-> io_oe_n && we_n && !ce_n; endproperty
	a_rel: assert property (p_rel) else $error("re drive");
	property p_lat; !(cle && ale); endproperty
	a_lat: assert property (p_lat) else $error("latch");
	property p_hold; $fell(we_n) |=> $stable(io_out) && $stable(cle) && $stable(ale); endproperty
	a_hold: assert property (p_hold) else $error("hold");
	property p_busy; $fell(we_n) && cle && low_r != 4'h0 |-> io_out inside {8'h70, 8'h71, 8'hff};
	endproperty
	a_busy: assert property (p_busy) else $error("cmd busy");
	property p_rst; $fell(rst) |-> ce_n && we_n && re_n && io_oe_n && wp_n && !cle; endproperty
	a_rst: assert property (p_rst) else $error("idle");
	c_wr: cover property ($fell(we_n) && cle);
	c_rd: cover property ($fell(re_n));
	c_bsy: cover property ($fell(ready_busy_out));
endmodule
bind ncp_cache_prog_host ncp_chk u_chk (.ref_clk, .rst, .ce_n, .cle, .ale, .we_n, .re_n,
	.wp_n, .io_out, .io_oe_n, .ready_busy_out);

// ---- testbench.sv ----
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin errors++; \
	$display("ERROR %0t got %h exp %h", $time, a, b); end end
module testbench
	import ncp_pkg::*;
;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [31:0] reg_rdata, d;
	logic ce_n, cle, ale, we_n, re_n, wp_n, io_oe_n, rb;
	logic [7:0] io_out, io_in;
	logic [1:0] fail_r = 2'h0;
	logic [7:0] xq[$];
	int errors = 0;
	int n_checks = 0;
	int seed = 32'h42447dbc;
	int s1 = 0;
	int s2 = 0;
	bit wp = 1'b0;
	always #20 ref_clk = ~ref_clk;
	ncp_cache_prog_host u_dut (.ref_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .ce_n, .cle, .ale, .we_n, .re_n, .wp_n, .io_out, .io_oe_n, .io_in,
		.ready_busy_out(rb));
	ncp_flash_model u_flash (.ce_n, .cle, .ale, .we_n, .re_n, .wp_n, .io_out, .fail_in(fail_r),
		.io_in, .ready_busy_out(rb));
	task automatic finish_test();
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// ====
	// Register port
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		@(posedge ref_clk);
	endtask
	task automatic rd(input logic [7:0] a);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
		@(posedge ref_clk);
	endtask
	// Starts an op, feeds and drains data, then checks commands and status
	task automatic run(input logic [3:0] op, input int n, input logic [47:0] c, input bit st);
		int i;
		logic [31:0] s;
		logic [7:0] b;
		logic [7:0] x;
		logic [8:0] e;
		fail_r <= 2'($random(seed));
		wr(REG_CTRL, {27'h0, wp, op});
		for (i = 0; i < 3000; i++) begin
			rd(REG_STAT);
			s = d;
			if (s[1]) begin
				b = 8'($random(seed));
				xq.push_back(b);
				wr(REG_DATA, {24'h0, b});
			end
			if (s[2]) begin
				rd(REG_DATA);
				`CHK(d[7:0], 8'ha5)
			end
			if (!s[0])
				break;
		end
		if (i == 3000) begin
			errors++;
			finish_test();
		end
		`CHK(u_flash.cq.size(), n)
		for (i = 0; i < n; i++) begin
			b = u_flash.cq.pop_front();
			`CHK(b, c[8 * (n - 1 - i) +: 8])
		end
		`CHK(u_flash.dq.size(), xq.size())
		while (xq.size() > 0 && u_flash.dq.size() > 0) begin
			x = xq.pop_front();
			b = u_flash.dq.pop_front();
			`CHK(b, x)
		end
		xq.delete();
		u_flash.dq.delete();
		if (n > 0 && op inside {4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h7}) begin
			s2 = s1;
			s1 = (op == 4'h3 || op == 4'h4) ? int'(fail_r) : int'(fail_r[0]);
		end
		if (op == 4'h9) begin
			s1 = 0;
			s2 = 0;
		end
		e = (op == 4'h3 || op == 4'h4) ? {1'b1, !wp, 2'b11, 2'(s2), 2'(s1), s1 != 0}
			: {1'b0, !wp, 2'b11, 3'b000, s2 != 0, s1 != 0};
		if (st) begin
			rd(REG_NSTAT);
			`CHK(d[8:0], e)
		end
	endtask
	initial begin
		repeat (2) @(posedge ref_clk);
		rst <= 1'b0;
		repeat (3) @(posedge ref_clk);
		wr(REG_DLEN, 32'h1);
		wr(REG_ROW0, 32'h100);
		run(4'h1, 3, 48'h80_15_70, 1'b1);
		wr(REG_ROW0, 32'h101);
		run(4'h2, 3, 48'h80_10_70, 1'b1);
		wr(REG_ROW1, 32'h140);
		wr(REG_ROW0, 32'h100);
		run(4'h3, 5, 48'h80_11_81_15_71, 1'b1);
		wr(REG_ROW1, 32'h101);
		wr(REG_ROW0, 32'h141);
		run(4'h4, 5, 48'h80_11_81_10_71, 1'b1);
		wp = 1'b1;
		wr(REG_CTRL, 32'h10);
		`CHK(wp_n, 1'b0)
		rd(REG_CTRL);
		`CHK(d[4], 1'b1)
		wr(REG_ROW0, 32'h100);
		run(4'h5, 2, 48'h00_3a, 1'b0);
		`CHK(wp_n, 1'b1)
		wp = 1'b0;
		wr(REG_CTRL, 32'h0);
		wr(REG_ROW0, 32'h101);
		run(4'h6, 3, 48'h8c_15_70, 1'b1);
		wr(REG_ROW0, 32'h102);
		run(4'h7, 3, 48'h8c_10_70, 1'b1);
		run(4'h9, 1, 48'hff, 1'b0);
		run(4'h8, 1, 48'h70, 1'b1);
		run(4'h6, 0, 48'h0, 1'b0);
		rd(REG_STAT);
		`CHK(d[3], 1'b1)
		wr(REG_CTRL, 32'h20);
		rd(REG_STAT);
		`CHK(d[3], 1'b0)
		rd(8'h20);
		`CHK(d, 32'h0)
		finish_test();
	end
endmodule
